/* power_cmd_consts.svh */
// constants for the power, command and offset register block
// assumes an 8-bit register address space reached by the primary serial slave
`ifndef POWER_CMD_CONSTS_SVH
`define POWER_CMD_CONSTS_SVH

`define ADDR_Y_OFFSET_TRIM    8'h72
`define ADDR_Z_OFFSET_TRIM    8'h73
`define ADDR_POWER_MODE       8'h7c
`define ADDR_SENSOR_ENABLE    8'h7d
`define ADDR_COMMAND_ENTRY    8'h7e

`define RESET_OFFSET_TRIM     8'h00
`define RESET_POWER_MODE      8'h03
`define RESET_SENSOR_ENABLE   8'h00
`define READ_COMMAND_ENTRY    8'h00

`define BIT_POWER_SAVE        0
`define BIT_FIFO_WAKEUP       1
`define BIT_AUX_ENABLE        0
`define BIT_ACC_ENABLE        2

`define CMD_NVM_STORE         8'ha0
`define CMD_FIFO_FLUSH        8'hb0
`define CMD_SOFT_RESET        8'hb6

`define NVM_STORE_CYCLES      4

`endif

/* power_cmd_pkg.sv */
// types for the power, command and offset register block
// assumes nothing beyond the constants header
package power_cmd_pkg;
   typedef enum logic [3:0]
   {
      cmd_idle  = 4'h1,
      cmd_store = 4'h2,
      cmd_flush = 4'h4,
      cmd_reset = 4'h8
   } cmd_state_type;
endpackage

/* offset_adder.sv */
// adds a signed offset to a signed sample, saturating at the sample range
// assumes samples and offsets are two's complement, combinational use
`timescale 1ns/10ps
`default_nettype none
module offset_adder
#(
   parameter int SAMPLE_WIDTH = 16,
   parameter int OFFSET_WIDTH = 8
)
(
   input  wire logic [SAMPLE_WIDTH-1:0] sample,
   input  wire logic [OFFSET_WIDTH-1:0] offset,
   input  wire logic                    apply,
   output logic      [SAMPLE_WIDTH-1:0] result
);
   logic signed [SAMPLE_WIDTH:0] sum;

   always_comb
   begin
      sum = {sample[SAMPLE_WIDTH-1], sample}
          + {{(SAMPLE_WIDTH+1-OFFSET_WIDTH){offset[OFFSET_WIDTH-1]}}, offset};
      if (!apply)
         result = sample;
      else if (sum[SAMPLE_WIDTH] != sum[SAMPLE_WIDTH-1])
         result = {sum[SAMPLE_WIDTH], {(SAMPLE_WIDTH-1){~sum[SAMPLE_WIDTH]}}};
      else
         result = sum[SAMPLE_WIDTH-1:0];
   end
endmodule
`default_nettype wire

/* power_command_offset_regs.sv */
// power mode, sensor enable, command and y/z offset registers
// assumes the primary serial slave decodes frames into one-cycle register
// strokes on core_clk; reads are answered from a register one cycle later
`timescale 1ns/10ps
`include "power_cmd_consts.svh"
`default_nettype none
module power_command_offset_regs
#(
   parameter int SAMPLE_WIDTH = 16,
   parameter int NVM_CYCLES   = `NVM_STORE_CYCLES
)
(
   input  wire logic                    core_clk,
   input  wire logic                    sys_rst,
   input  wire logic                    clk_en,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   input  wire logic [7:0]              reg_addr,
   input  wire logic [7:0]              reg_wdata,
   input  wire logic                    offset_apply,
   input  wire logic                    measuring,
   input  wire logic                    fifo_int_seen,
   input  wire logic [SAMPLE_WIDTH-1:0] y_sample,
   input  wire logic [SAMPLE_WIDTH-1:0] z_sample,
   output logic      [7:0]              reg_rdata,
   output logic                         reg_rvalid,
   output logic                         slow_clk_sel,
   output logic                         fifo_read_allow,
   output logic                         acc_enable,
   output logic                         aux_path_enable,
   output logic                         nvm_store_busy,
   output logic      [15:0]             nvm_image,
   output logic                         fifo_flush,
   output logic                         soft_reset_pulse,
   output logic      [SAMPLE_WIDTH-1:0] y_out,
   output logic      [SAMPLE_WIDTH-1:0] z_out
);
   localparam logic [7:0] NVM_LAST = 8'(NVM_CYCLES - 1);

   logic [7:0] y_offset_trim;
   logic [7:0] z_offset_trim;
   logic [7:0] power_mode_config;
   logic [7:0] sensor_power_enable;
   logic [7:0] next_y_offset_trim;
   logic [7:0] next_z_offset_trim;
   logic [7:0] next_power_mode_config;
   logic [7:0] next_sensor_power_enable;
   logic [7:0] next_reg_rdata;
   logic       next_reg_rvalid;

   power_cmd_pkg::cmd_state_type cmd_state;
   power_cmd_pkg::cmd_state_type next_cmd_state;
   logic [7:0]  nvm_count;
   logic [7:0]  next_nvm_count;
   logic [15:0] next_nvm_image;
   logic        next_fifo_flush;
   logic        next_soft_reset;
   logic        next_slow_clk_sel;
   logic        next_fifo_read_allow;
   logic [SAMPLE_WIDTH-1:0] y_sum;
   logic [SAMPLE_WIDTH-1:0] z_sum;

   // register file: only host-initiated strokes change anything
   always_comb
   begin
      next_y_offset_trim       = y_offset_trim;
      next_z_offset_trim       = z_offset_trim;
      next_power_mode_config   = power_mode_config;
      next_sensor_power_enable = sensor_power_enable;
      next_reg_rvalid          = reg_rd;
      next_reg_rdata           = 8'h00;
      if (cmd_state == power_cmd_pkg::cmd_reset)
      begin
         // soft reset wins over any write landing in the same cycle
         next_y_offset_trim       = `RESET_OFFSET_TRIM;
         next_z_offset_trim       = `RESET_OFFSET_TRIM;
         next_power_mode_config   = `RESET_POWER_MODE;
         next_sensor_power_enable = `RESET_SENSOR_ENABLE;
      end
      else if (reg_wr)
      begin
         unique case (reg_addr)
            `ADDR_Y_OFFSET_TRIM: next_y_offset_trim = reg_wdata;
            `ADDR_Z_OFFSET_TRIM: next_z_offset_trim = reg_wdata;
            `ADDR_POWER_MODE:    next_power_mode_config = {6'h00, reg_wdata[1:0]};
            `ADDR_SENSOR_ENABLE: next_sensor_power_enable =
               {5'h00, reg_wdata[`BIT_ACC_ENABLE], 1'b0, reg_wdata[`BIT_AUX_ENABLE]};
            default: ;
         endcase
      end
      if (reg_rd)
      begin
         unique case (reg_addr)
            `ADDR_Y_OFFSET_TRIM: next_reg_rdata = y_offset_trim;
            `ADDR_Z_OFFSET_TRIM: next_reg_rdata = z_offset_trim;
            `ADDR_POWER_MODE:    next_reg_rdata = power_mode_config;
            `ADDR_SENSOR_ENABLE: next_reg_rdata = sensor_power_enable;
            `ADDR_COMMAND_ENTRY: next_reg_rdata = `READ_COMMAND_ENTRY;
            default:             next_reg_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         y_offset_trim       <= `RESET_OFFSET_TRIM;
         z_offset_trim       <= `RESET_OFFSET_TRIM;
         power_mode_config   <= `RESET_POWER_MODE;
         sensor_power_enable <= `RESET_SENSOR_ENABLE;
         reg_rdata           <= 8'h00;
         reg_rvalid          <= 1'b0;
      end
      else if (clk_en)
      begin
         y_offset_trim       <= next_y_offset_trim;
         z_offset_trim       <= next_z_offset_trim;
         power_mode_config   <= next_power_mode_config;
         sensor_power_enable <= next_sensor_power_enable;
         reg_rdata           <= next_reg_rdata;
         reg_rvalid          <= next_reg_rvalid;
      end
   end

   // command sequencer; store takes a fixed number of cycles to program
   always_comb
   begin
      next_cmd_state  = cmd_state;
      next_nvm_count  = nvm_count;
      next_nvm_image  = nvm_image;
      next_fifo_flush = 1'b0;
      next_soft_reset = 1'b0;
      unique case (cmd_state)
         power_cmd_pkg::cmd_idle:
         begin
            if (reg_wr && reg_addr == `ADDR_COMMAND_ENTRY)
            begin
               unique case (reg_wdata)
                  `CMD_NVM_STORE:
                  begin
                     next_cmd_state = power_cmd_pkg::cmd_store;
                     next_nvm_count = 8'h00;
                  end
                  `CMD_FIFO_FLUSH:
                  begin
                     next_cmd_state  = power_cmd_pkg::cmd_flush;
                     next_fifo_flush = 1'b1;
                  end
                  `CMD_SOFT_RESET:
                  begin
                     next_cmd_state  = power_cmd_pkg::cmd_reset;
                     next_soft_reset = 1'b1;
                  end
                  default: ;
               endcase
            end
         end
         power_cmd_pkg::cmd_store:
         begin
            if (nvm_count == NVM_LAST)
            begin
               next_nvm_image = {z_offset_trim, y_offset_trim};
               next_cmd_state = power_cmd_pkg::cmd_idle;
            end
            else
               next_nvm_count = nvm_count + 8'h01;
         end
         power_cmd_pkg::cmd_flush: next_cmd_state = power_cmd_pkg::cmd_idle;
         power_cmd_pkg::cmd_reset: next_cmd_state = power_cmd_pkg::cmd_idle;
         default:                  next_cmd_state = power_cmd_pkg::cmd_idle;
      endcase
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cmd_state        <= power_cmd_pkg::cmd_idle;
         nvm_count        <= 8'h00;
         nvm_image        <= 16'h0000;
         fifo_flush       <= 1'b0;
         soft_reset_pulse <= 1'b0;
      end
      else if (clk_en)
      begin
         cmd_state        <= next_cmd_state;
         nvm_count        <= next_nvm_count;
         nvm_image        <= next_nvm_image;
         fifo_flush       <= next_fifo_flush;
         soft_reset_pulse <= next_soft_reset;
      end
   end

   // power and sensor controls, all registered
   always_comb
   begin
      next_slow_clk_sel = power_mode_config[`BIT_POWER_SAVE] && !measuring;
      // blocked only while power saving is really in force
      next_fifo_read_allow = !next_slow_clk_sel
         || (power_mode_config[`BIT_FIFO_WAKEUP] && fifo_int_seen);
   end

   offset_adder #(.SAMPLE_WIDTH(SAMPLE_WIDTH), .OFFSET_WIDTH(8)) y_add
   (
      .sample (y_sample),
      .offset (y_offset_trim),
      .apply  (offset_apply),
      .result (y_sum)
   );

   offset_adder #(.SAMPLE_WIDTH(SAMPLE_WIDTH), .OFFSET_WIDTH(8)) z_add
   (
      .sample (z_sample),
      .offset (z_offset_trim),
      .apply  (offset_apply),
      .result (z_sum)
   );

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         slow_clk_sel    <= 1'b0;
         fifo_read_allow <= 1'b0;
         acc_enable      <= 1'b0;
         aux_path_enable <= 1'b0;
         nvm_store_busy  <= 1'b0;
         y_out           <= '0;
         z_out           <= '0;
      end
      else if (clk_en)
      begin
         slow_clk_sel    <= next_slow_clk_sel;
         fifo_read_allow <= next_fifo_read_allow;
         acc_enable      <= sensor_power_enable[`BIT_ACC_ENABLE];
         aux_path_enable <= sensor_power_enable[`BIT_AUX_ENABLE];
         nvm_store_busy  <= (next_cmd_state == power_cmd_pkg::cmd_store);
         y_out           <= y_sum;
         z_out           <= z_sum;
      end
   end

   AST_RD_ZERO: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_rd && reg_addr == `ADDR_COMMAND_ENTRY |=> reg_rdata == 8'h00)
      else $error("command register read not zero");
   AST_Y_WRITE: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_wr && reg_addr == `ADDR_Y_OFFSET_TRIM && cmd_state != power_cmd_pkg::cmd_reset
      |=> y_offset_trim == $past(reg_wdata))
      else $error("y trim not written");
   AST_Z_WRITE: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_wr && reg_addr == `ADDR_Z_OFFSET_TRIM && cmd_state != power_cmd_pkg::cmd_reset
      |=> z_offset_trim == $past(reg_wdata))
      else $error("z trim not written");
   AST_SLOW: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && !power_mode_config[`BIT_POWER_SAVE] |=> !slow_clk_sel)
      else $error("slow clock with power save off");
   AST_FIFO_BLOCK: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && next_slow_clk_sel && !power_mode_config[`BIT_FIFO_WAKEUP] |=> !fifo_read_allow)
      else $error("fifo read allowed in power save");
   AST_SOFT_RESET: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_wr && reg_addr == `ADDR_COMMAND_ENTRY && reg_wdata == `CMD_SOFT_RESET
      && cmd_state == power_cmd_pkg::cmd_idle ##1 clk_en
      |=> power_mode_config == `RESET_POWER_MODE && y_offset_trim == 8'h00)
      else $error("soft reset did not restore defaults");
   AST_FLUSH: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_wr && reg_addr == `ADDR_COMMAND_ENTRY && reg_wdata == `CMD_FIFO_FLUSH
      && cmd_state == power_cmd_pkg::cmd_idle |=> fifo_flush ##1 (!clk_en || !fifo_flush))
      else $error("flush pulse wrong");
   AST_AUX: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en ##1 clk_en |-> aux_path_enable == $past(sensor_power_enable[`BIT_AUX_ENABLE]))
      else $error("aux path does not follow enable");
   AST_BAD_CMD: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_wr && reg_addr == `ADDR_COMMAND_ENTRY && cmd_state == power_cmd_pkg::cmd_idle
      && reg_wdata != `CMD_NVM_STORE && reg_wdata != `CMD_FIFO_FLUSH
      && reg_wdata != `CMD_SOFT_RESET |=> cmd_state == power_cmd_pkg::cmd_idle)
      else $error("undefined command changed state");

   COV_STORE: cover property (@(posedge core_clk) disable iff (sys_rst)
      cmd_state == power_cmd_pkg::cmd_store ##1 cmd_state == power_cmd_pkg::cmd_idle);
   COV_RESET: cover property (@(posedge core_clk) disable iff (sys_rst) soft_reset_pulse);
   COV_WAKE: cover property (@(posedge core_clk) disable iff (sys_rst)
      slow_clk_sel && fifo_read_allow);
endmodule
`default_nettype wire

/* host_stroke_master.sv */
// host model that issues one-cycle register strokes to the register block
// assumes the block takes a stroke on the rising edge of core_clk
`timescale 1ns/10ps
`default_nettype none
module host_stroke_master
(
   input  wire logic       core_clk,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata
);
   initial
   begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   // every access starts here; the block only answers
   task automatic stroke(input logic wr, input logic [7:0] addr, input logic [7:0] data);
      @(negedge core_clk);
      reg_wr = wr;
      reg_rd = ~wr;
      reg_addr = addr;
      reg_wdata = data;
      @(negedge core_clk);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      // a released bus must not keep showing the last value
      reg_addr = ~addr;
      reg_wdata = ~data;
   endtask

   task automatic read(input logic [7:0] addr, output logic [7:0] data);
      int n;
      stroke(1'b0, addr, 8'h00);
      n = 0;
      while (reg_rvalid !== 1'b1 && n < 4)
      begin
         @(negedge core_clk);
         n++;
      end
      data = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
   endtask
endmodule
`default_nettype wire

/* power_command_offset_regs_tb.sv */
// self-checking bench for the power, command and offset register block
// assumes the host model drives all register strokes
`timescale 1ns/10ps
`default_nettype none
module power_command_offset_regs_tb;
   localparam int NVM_N = 4;
   logic        core_clk, sys_rst, clk_en, offset_apply, measuring, fifo_int_seen;
   logic        reg_wr, reg_rd, reg_rvalid, slow_clk_sel, fifo_read_allow, acc_enable;
   logic        aux_path_enable, nvm_store_busy, fifo_flush, soft_reset_pulse;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd;
   logic [15:0] y_sample, z_sample, y_out, z_out, nvm_image;
   int          n_fail, samples_checked, n_flush, n_reset, n_busy;

   power_command_offset_regs #(.SAMPLE_WIDTH(16), .NVM_CYCLES(NVM_N)) u_dut
   (
      .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .offset_apply(offset_apply), .measuring(measuring), .fifo_int_seen(fifo_int_seen),
      .y_sample(y_sample), .z_sample(z_sample), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .slow_clk_sel(slow_clk_sel),
      .fifo_read_allow(fifo_read_allow), .acc_enable(acc_enable),
      .aux_path_enable(aux_path_enable), .nvm_store_busy(nvm_store_busy),
      .nvm_image(nvm_image), .fifo_flush(fifo_flush), .soft_reset_pulse(soft_reset_pulse),
      .y_out(y_out), .z_out(z_out)
   );

   host_stroke_master u_host
   (
      .core_clk(core_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata)
   );

   always #5 core_clk = ~core_clk;

   // pulse and busy lengths are judged by counting cycles
   always @(posedge core_clk)
   begin
      if (fifo_flush === 1'b1) n_flush++;
      if (soft_reset_pulse === 1'b1) n_reset++;
      if (nvm_store_busy === 1'b1) n_busy++;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      u_host.stroke(1'b1, addr, data);
   endtask

   task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
      u_host.read(addr, rd);
      check({8'h00, rd}, {8'h00, exp});
   endtask

   task automatic settle();
      repeat (3) @(negedge core_clk);
   endtask

   task automatic tally_and_finish();
      if (n_fail == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      repeat (5000) @(posedge core_clk);
      n_fail++;
      tally_and_finish();
   end

   initial
   begin
      core_clk = 1'b0;
      sys_rst = 1'b1;
      clk_en = 1'b1;
      offset_apply = 1'b0;
      measuring = 1'b0;
      fifo_int_seen = 1'b0;
      y_sample = 16'h0100;
      z_sample = 16'h0100;
      repeat (10) @(negedge core_clk);
      sys_rst = 1'b0;
      settle();
      check(16'(slow_clk_sel), 16'h0001);
      check(16'(fifo_read_allow), 16'h0000);
      rchk(8'h72, 8'h00);
      rchk(8'h73, 8'h00);
      rchk(8'h7c, 8'h03);
      rchk(8'h7d, 8'h00);
      wr(8'h72, 8'h5a);
      wr(8'h73, 8'ha5);
      wr(8'h74, 8'h33);
      rchk(8'h72, 8'h5a);
      rchk(8'h73, 8'ha5);
      rchk(8'h74, 8'h00);
      offset_apply = 1'b1;
      settle();
      check(y_out, 16'h015a);
      check(z_out, 16'h00a5);
      // the adder saturates instead of wrapping
      y_sample = 16'h7fff;
      settle();
      check(y_out, 16'h7fff);
      wr(8'h7d, 8'hff);
      rchk(8'h7d, 8'h05);
      check({14'h0000, acc_enable, aux_path_enable}, 16'h0003);
      wr(8'h7d, 8'h04);
      settle();
      check({14'h0000, acc_enable, aux_path_enable}, 16'h0002);
      wr(8'h7c, 8'h00);
      fifo_int_seen = 1'b1;
      settle();
      check({14'h0000, slow_clk_sel, fifo_read_allow}, 16'h0001);
      wr(8'h7c, 8'h01);
      settle();
      check({14'h0000, slow_clk_sel, fifo_read_allow}, 16'h0002);
      wr(8'h7c, 8'h03);
      settle();
      check(16'(fifo_read_allow), 16'h0001);
      measuring = 1'b1;
      settle();
      check(16'(slow_clk_sel), 16'h0000);
      wr(8'h7e, 8'h12);
      wr(8'h7e, 8'hff);
      settle();
      check(16'(n_flush + n_reset + n_busy), 16'h0000);
      rchk(8'h7d, 8'h04);
      wr(8'h7e, 8'hb0);
      settle();
      check(16'(n_flush), 16'h0001);
      rchk(8'h7e, 8'h00);
      // a flush sent while the store runs has to be dropped
      wr(8'h7e, 8'ha0);
      wr(8'h7e, 8'hb0);
      repeat (3) settle();
      check(16'(n_busy), 16'(NVM_N));
      check(nvm_image, 16'ha55a);
      check(16'(n_flush), 16'h0001);
      // a stroke while the clock enable is low must leave the trim alone
      clk_en = 1'b0;
      wr(8'h72, 8'h11);
      clk_en = 1'b1;
      rchk(8'h72, 8'h5a);
      // move power mode off its default so the soft reset has work to do
      wr(8'h7c, 8'h01);
      rchk(8'h7c, 8'h01);
      wr(8'h7e, 8'hb6);
      settle();
      check(16'(n_reset), 16'h0001);
      rchk(8'h7d, 8'h00);
      rchk(8'h7c, 8'h03);
      rchk(8'h72, 8'h00);
      rchk(8'h73, 8'h00);
      tally_and_finish();
   end
endmodule
`default_nettype wire
